// ---- design/lca_regs.sv ----
// APB register bank for line configuration, driver disable and alarms
//
// Contract
// - Three-bit channel index picks which channel the data register reaches.
// - Data writes change only the indexed channel; reads return its config.
// - All registers and per-channel configs clear to zero at reset.
// - Impedance bit one means internal, zero external, for receive and transmit.
// - Four-bit shape code sets impedance and transmitted pulse per channel.
// - Codes 0000 and 1000 select E1, 120 or 75 ohm, twelve samples.
// - Codes 0001 and 0010 select T1/J1 DS1 pulses, fourteen samples.
// - Codes 0011 to 0111 select T1/J1 cable lengths, thirteen samples.
// - Disable bit n puts channel n transmit driver into high impedance.
// - Alarm status bit n reads one while channel n detects alarm.
// - Alarm change latches into interrupt status only when enabled.
// - Interrupt status bit sets on any enabled change and holds until cleared.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module lca_regs
    import lca_pkg::*;
#(
    parameter int NUM_CH = LCA_NUM_CH
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [LCA_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [NUM_CH-1:0]       ais_detect,
    output logic      [NUM_CH-1:0]       tx_driver_hiz,
    output logic      [NUM_CH-1:0]       impedance_source_sel,
    output logic      [NUM_CH*4-1:0]     pulse_shape_code,
    output logic      [NUM_CH-1:0]       chan_e1_mode,
    output logic      [NUM_CH*2-1:0]     chan_line_load,
    output logic      [NUM_CH*4-1:0]     chan_phase_samples,
    output logic      [NUM_CH-1:0]       chan_shape_rsvd,
    output logic                         ais_irq
);
    // ==========================================================
    // State
    logic [LCA_SEL_W-1:0]  sel_q, sel_d;
    logic [LCA_CODE_W-1:0] code_q [NUM_CH];
    logic [LCA_CODE_W-1:0] code_d [NUM_CH];
    logic [NUM_CH-1:0]     imp_q, imp_d;
    logic [NUM_CH-1:0]     hiz_q, hiz_d;
    logic [NUM_CH-1:0]     en_q, en_d;
    logic [NUM_CH-1:0]     sts_q, sts_d;
    logic [NUM_CH-1:0]     prev_q, prev_d;
    logic                  irq_q, irq_d;
    logic [31:0]           rdata_q, rdata_d;
    logic                  err_q, err_d;

    // Decode wires
    logic                  setup_ph;
    logic                  access_ph;
    logic                  wr_ok;
    logic                  hit_sel, hit_cfg, hit_hiz;
    logic                  hit_ais, hit_en, hit_sts;
    logic                  mapped;
    logic [NUM_CH-1:0]     ais_now;
    logic [NUM_CH-1:0]     ais_chg;
    logic [NUM_CH-1:0]     sts_clr;
    logic [31:0]           rd_mux;

    // ==========================================================
    // Alarm inputs cross in through the synchroniser
    lca_sync #(
        .WIDTH    (NUM_CH)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ais_detect),
        .sync_out (ais_now)
    );

    // ==========================================================
    // APB phase and address decode
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    // Address match chain
    always_comb begin
        hit_sel = 1'b0;
        hit_cfg = 1'b0;
        hit_hiz = 1'b0;
        hit_ais = 1'b0;
        hit_en  = 1'b0;
        hit_sts = 1'b0;
        if (paddr == LCA_ADDR_CHAN_SEL) begin
            hit_sel = 1'b1;
        end else if (paddr == LCA_ADDR_CFG_DATA) begin
            hit_cfg = 1'b1;
        end else if (paddr == LCA_ADDR_HIZ) begin
            hit_hiz = 1'b1;
        end else if (paddr == LCA_ADDR_AIS_STS) begin
            hit_ais = 1'b1;
        end else if (paddr == LCA_ADDR_IRQ_EN) begin
            hit_en = 1'b1;
        end else if (paddr == LCA_ADDR_IRQ_STS) begin
            hit_sts = 1'b1;
        end
    end

    assign mapped = hit_sel | hit_cfg | hit_hiz | hit_ais | hit_en | hit_sts;
    // Write takes effect in the access phase, low byte lane only
    assign wr_ok  = access_ph & pwrite & pstrb[0];

    // ==========================================================
    // Read multiplexer, reserved bits read as zero
    always_comb begin
        rd_mux = LCA_RST_WORD;
        if (hit_sel) begin
            rd_mux[LCA_SEL_W-1:0] = sel_q;
        end else if (hit_cfg) begin
            rd_mux[LCA_IMP_BIT] = imp_q[sel_q];
            rd_mux[LCA_CODE_W-1:0] = code_q[sel_q];
        end else if (hit_hiz) begin
            rd_mux[NUM_CH-1:0] = hiz_q;
        end else if (hit_ais) begin
            rd_mux[NUM_CH-1:0] = ais_now;
        end else if (hit_en) begin
            rd_mux[NUM_CH-1:0] = en_q;
        end else if (hit_sts) begin
            rd_mux[NUM_CH-1:0] = sts_q;
        end
    end

    // Answer prepared in setup, presented in access
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup_ph) begin
            rdata_d = pwrite ? LCA_RST_WORD : rd_mux;
            err_d   = ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= LCA_RST_WORD;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = access_ph & err_q;

    // ==========================================================
    // Configuration registers
    always_comb begin
        sel_d = sel_q;
        imp_d = imp_q;
        hiz_d = hiz_q;
        en_d  = en_q;
        for (int i = 0; i < NUM_CH; i++) begin
            code_d[i] = code_q[i];
        end
        if (wr_ok && hit_sel) begin
            sel_d = pwdata[LCA_SEL_W-1:0];
        end
        if (wr_ok && hit_cfg) begin
            imp_d[sel_q]  = pwdata[LCA_IMP_BIT];
            code_d[sel_q] = pwdata[LCA_CODE_W-1:0];
        end
        if (wr_ok && hit_hiz) begin
            hiz_d = pwdata[NUM_CH-1:0];
        end
        if (wr_ok && hit_en) begin
            en_d = pwdata[NUM_CH-1:0];
        end
    end

    // Everything clears on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= LCA_RST_SEL;
            imp_q <= LCA_RST_BYTE[NUM_CH-1:0];
            hiz_q <= LCA_RST_BYTE[NUM_CH-1:0];
            en_q  <= LCA_RST_BYTE[NUM_CH-1:0];
            for (int i = 0; i < NUM_CH; i++) begin
                code_q[i] <= LCA_RST_CODE;
            end
        end else begin
            sel_q <= sel_d;
            imp_q <= imp_d;
            hiz_q <= hiz_d;
            en_q  <= en_d;
            for (int i = 0; i < NUM_CH; i++) begin
                code_q[i] <= code_d[i];
            end
        end
    end

    // ==========================================================
    // Alarm change detect and interrupt status
    assign ais_chg = ais_now ^ prev_q;
    assign sts_clr = (wr_ok && hit_sts) ? pwdata[NUM_CH-1:0]
                                        : LCA_RST_BYTE[NUM_CH-1:0];

    // Set wins over a same-cycle write-one clear
    always_comb begin
        prev_d = ais_now;
        sts_d  = (sts_q & ~sts_clr) | (ais_chg & en_q);
        irq_d  = |(sts_q & en_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= LCA_RST_BYTE[NUM_CH-1:0];
            sts_q  <= LCA_RST_BYTE[NUM_CH-1:0];
            irq_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            sts_q  <= sts_d;
            irq_q  <= irq_d;
        end
    end

    assign ais_irq       = irq_q;
    assign tx_driver_hiz = hiz_q;

    // ==========================================================
    // Per-channel decode of the stored shape settings
    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        lca_shape_if shp ();
        assign shp.code = code_q[g];
        assign shp.imp  = imp_q[g];
        lca_shape_dec u_dec (
            .pclk    (pclk),
            .presetn (presetn),
            .shp     (shp)
        );
        assign impedance_source_sel[g]  = shp.imp_int;
        assign pulse_shape_code[g*4 +: 4] = code_q[g];
        assign chan_e1_mode[g]          = (shp.mode == LCA_MODE_E1);
        assign chan_line_load[g*2 +: 2] = shp.load;
        assign chan_phase_samples[g*4 +: 4] = shp.spu;
        assign chan_shape_rsvd[g]       = shp.rsvd;
    end

    // ==========================================================
    // Checks
    logic seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    reset_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> sel_q == LCA_RST_SEL && hiz_q == '0 && en_q == '0
        && sts_q == '0 && imp_q == '0 && code_q[0] == LCA_RST_CODE)
        else $error("Registers not clear after reset");

    sel_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && hit_sel |=> sel_q == $past(pwdata[2:0]))
        else $error("Channel index write lost");

    cfg_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && hit_cfg |=> code_q[$past(sel_q)] == $past(pwdata[3:0])
        && imp_q[$past(sel_q)] == $past(pwdata[4]))
        else $error("Config write missed indexed channel");

    cfg_other_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && hit_cfg && sel_q != 3'h0 |=> code_q[0] == $past(code_q[0]))
        else $error("Config write touched another channel");

    cfg_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !pwrite && hit_cfg |=>
        prdata[4:0] == {$past(imp_q[sel_q]), $past(code_q[sel_q])}
        && prdata[7:5] == 3'h0)
        else $error("Config read wrong");

    hiz_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && hit_hiz |=> tx_driver_hiz == $past(pwdata[7:0]))
        else $error("Driver disable not applied");

    ais_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !pwrite && hit_ais |=> prdata[7:0] == $past(ais_now))
        else $error("Alarm status read wrong");

    // Channel one is the one the bench changes while masked
    gate_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ais_chg[1] && !en_q[1] && !sts_q[1] |=> !sts_q[1])
        else $error("Masked alarm change latched");

    sts_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ais_chg[0] && en_q[0] |=> sts_q[0] ##1 ais_irq)
        else $error("Enabled alarm change not latched");

    sts_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sts_q[0] && !(wr_ok && hit_sts && pwdata[0]) |=> sts_q[0])
        else $error("Interrupt status dropped without clear");

    irq_out_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        |(sts_q & en_q) |=> ais_irq)
        else $error("Interrupt output not raised");

    irq_fall_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|(sts_q & en_q)) |=> !ais_irq)
        else $error("Interrupt output not lowered");

    // Error answer follows an unmapped setup
    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !mapped |=> pslverr)
        else $error("Unmapped access not flagged");
endmodule : lca_regs

// ---- design/lca_shape_dec.sv ----
// Registered decoder from shape code to standard, load and sample count
`timescale 1ns/1ps
module lca_shape_dec
    import lca_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    lca_shape_if.dec  shp
);
    lca_mode_t  mode_d, mode_q;
    lca_load_t  load_d, load_q;
    logic [3:0] spu_d, spu_q;
    logic       rsvd_d, rsvd_q;
    logic       imp_d, imp_q;
    // ==========================================================
    // Code table
    always_comb begin
        mode_d = LCA_MODE_RSVD;
        load_d = LCA_LOAD_NONE;
        spu_d  = LCA_SPU_NONE;
        rsvd_d = 1'b1;
        imp_d  = shp.imp;
        if (shp.code == LCA_CODE_E1_120 || shp.code == LCA_CODE_E1_75) begin
            mode_d = LCA_MODE_E1;
            load_d = (shp.code == LCA_CODE_E1_75) ? LCA_LOAD_75 : LCA_LOAD_120;
            spu_d  = LCA_SPU_E1;
            rsvd_d = 1'b0;
        end else if (shp.code == LCA_CODE_DS1_US ||
                     shp.code == LCA_CODE_DS1_0DB) begin
            mode_d = LCA_MODE_T1J1;
            load_d = LCA_LOAD_100;
            spu_d  = LCA_SPU_DS1;
            rsvd_d = 1'b0;
        end else if (shp.code >= LCA_CODE_LEN_LO &&
                     shp.code <= LCA_CODE_LEN_HI) begin
            mode_d = LCA_MODE_T1J1;
            load_d = LCA_LOAD_100;
            spu_d  = LCA_SPU_LEN;
            rsvd_d = 1'b0;
        end
    end
    // Decoded outputs held in flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= LCA_MODE_E1;
            load_q <= LCA_LOAD_120;
            spu_q  <= LCA_SPU_E1;
            rsvd_q <= 1'b0;
            imp_q  <= 1'b0;
        end else begin
            mode_q <= mode_d;
            load_q <= load_d;
            spu_q  <= spu_d;
            rsvd_q <= rsvd_d;
            imp_q  <= imp_d;
        end
    end
    assign shp.mode    = mode_q;
    assign shp.load    = load_q;
    assign shp.spu     = spu_q;
    assign shp.rsvd    = rsvd_q;
    assign shp.imp_int = imp_q;
    // ==========================================================
    // Checks
    e1_decode_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(shp.code) == LCA_CODE_E1_120 ||
         $past(shp.code) == LCA_CODE_E1_75)
        |-> shp.mode == LCA_MODE_E1 && shp.spu == LCA_SPU_E1)
        else $error("E1 code decoded wrongly");
    ds1_decode_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(shp.code) == LCA_CODE_DS1_US ||
         $past(shp.code) == LCA_CODE_DS1_0DB)
        |-> shp.mode == LCA_MODE_T1J1 && shp.spu == LCA_SPU_DS1)
        else $error("DS1 code decoded wrongly");
    len_decode_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(shp.code) >= LCA_CODE_LEN_LO &&
         $past(shp.code) <= LCA_CODE_LEN_HI)
        |-> shp.load == LCA_LOAD_100 && shp.spu == LCA_SPU_LEN)
        else $error("Cable length code decoded wrongly");
    rsvd_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        shp.rsvd == ($past(shp.code) > LCA_CODE_E1_75))
        else $error("Reserved code flag wrong");
endmodule : lca_shape_dec

// ---- design/lca_sync.sv ----
// Three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
module lca_sync
    import lca_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // ==========================================================
    // Per-bit chain
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_bit
        logic s1_q, s2_q, s3_q, out_q;
        logic out_d;
        // Output follows only when stages two and three agree
        always_comb begin
            out_d = (s2_q == s3_q) ? s3_q : out_q;
        end
        // Stage one feeds stage two alone
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q  <= 1'b0;
                s2_q  <= 1'b0;
                s3_q  <= 1'b0;
                out_q <= 1'b0;
            end else begin
                s1_q  <= async_in[g];
                s2_q  <= s1_q;
                s3_q  <= s2_q;
                out_q <= out_d;
            end
        end
        assign sync_out[g] = out_q;
    end
endmodule : lca_sync

// ---- include/lca_pkg.sv ----
// Constants and types for the line configuration and alarm register bank
package lca_pkg;
    // ==========================================================
    // Widths and counts
    localparam int LCA_NUM_CH  = 8;
    localparam int LCA_ADDR_W  = 8;
    localparam int LCA_SEL_W   = 3;
    localparam int LCA_CODE_W  = 4;
    localparam int LCA_SPU_W   = 4;
    localparam int LCA_BYTE_W  = 8;
    localparam int LCA_IMP_BIT = 4;
    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] LCA_IDX_CHAN_SEL = 8'h10;
    localparam logic [7:0] LCA_IDX_CFG_DATA = 8'h11;
    localparam logic [7:0] LCA_IDX_HIZ      = 8'h12;
    localparam logic [7:0] LCA_IDX_AIS_STS  = 8'h13;
    localparam logic [7:0] LCA_IDX_IRQ_EN   = 8'h14;
    localparam logic [7:0] LCA_IDX_IRQ_STS  = 8'h15;
    localparam logic [7:0] LCA_ADDR_CHAN_SEL = {LCA_IDX_CHAN_SEL[5:0], 2'h0};
    localparam logic [7:0] LCA_ADDR_CFG_DATA = {LCA_IDX_CFG_DATA[5:0], 2'h0};
    localparam logic [7:0] LCA_ADDR_HIZ      = {LCA_IDX_HIZ[5:0], 2'h0};
    localparam logic [7:0] LCA_ADDR_AIS_STS  = {LCA_IDX_AIS_STS[5:0], 2'h0};
    localparam logic [7:0] LCA_ADDR_IRQ_EN   = {LCA_IDX_IRQ_EN[5:0], 2'h0};
    localparam logic [7:0] LCA_ADDR_IRQ_STS  = {LCA_IDX_IRQ_STS[5:0], 2'h0};
    // ==========================================================
    // Reset values
    localparam logic [7:0]  LCA_RST_BYTE = 8'h00;
    localparam logic [2:0]  LCA_RST_SEL  = 3'h0;
    localparam logic [3:0]  LCA_RST_CODE = 4'h0;
    localparam logic [31:0] LCA_RST_WORD = 32'h0000_0000;
    // ==========================================================
    // Shape codes and phase samples per unit interval
    localparam logic [3:0] LCA_CODE_E1_120   = 4'h0;
    localparam logic [3:0] LCA_CODE_DS1_US   = 4'h1;
    localparam logic [3:0] LCA_CODE_DS1_0DB  = 4'h2;
    localparam logic [3:0] LCA_CODE_LEN_LO   = 4'h3;
    localparam logic [3:0] LCA_CODE_LEN_HI   = 4'h7;
    localparam logic [3:0] LCA_CODE_E1_75    = 4'h8;
    localparam logic [3:0] LCA_SPU_E1        = 4'hc;
    localparam logic [3:0] LCA_SPU_DS1       = 4'he;
    localparam logic [3:0] LCA_SPU_LEN       = 4'hd;
    localparam logic [3:0] LCA_SPU_NONE      = 4'h0;
    // ==========================================================
    // Operating standard and line load
    typedef enum logic [1:0] {
        LCA_MODE_E1   = 2'b00,
        LCA_MODE_T1J1 = 2'b01,
        LCA_MODE_RSVD = 2'b10
    } lca_mode_t;
    typedef enum logic [1:0] {
        LCA_LOAD_120  = 2'b00,
        LCA_LOAD_75   = 2'b01,
        LCA_LOAD_100  = 2'b10,
        LCA_LOAD_NONE = 2'b11
    } lca_load_t;
endpackage : lca_pkg

// ---- include/lca_shape_if.sv ----
// Per-channel shape configuration and its decoded meaning
`timescale 1ns/1ps
interface lca_shape_if;
    import lca_pkg::*;
    logic [3:0] code;
    logic       imp;
    lca_mode_t  mode;
    lca_load_t  load;
    logic [3:0] spu;
    logic       rsvd;
    logic       imp_int;
    modport src (output code, imp, input mode, load, spu, rsvd, imp_int);
    modport dec (input code, imp, output mode, load, spu, rsvd, imp_int);
endinterface : lca_shape_if

// ---- tb/lca_regs_tb_top.sv ----
// Self-checking testbench for the line configuration register bank
`timescale 1ns/1ps
module lca_regs_tb_top;
    import lca_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  ais_detect;
    logic [7:0]  tx_driver_hiz;
    logic [7:0]  impedance_source_sel;
    logic [31:0] pulse_shape_code;
    logic [7:0]  chan_e1_mode;
    logic [15:0] chan_line_load;
    logic [31:0] chan_phase_samples;
    logic [7:0]  chan_shape_rsvd;
    logic        ais_irq;
    logic [31:0] rd;
    logic        err;
    int          errors;
    int          comparisons;

    // ==========================================================
    // Design under test
    lca_regs #(.NUM_CH(8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ais_detect(ais_detect), .tx_driver_hiz(tx_driver_hiz),
        .impedance_source_sel(impedance_source_sel),
        .pulse_shape_code(pulse_shape_code), .chan_e1_mode(chan_e1_mode),
        .chan_line_load(chan_line_load),
        .chan_phase_samples(chan_phase_samples),
        .chan_shape_rsvd(chan_shape_rsvd), .ais_irq(ais_irq)
    );

    // Clock at 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Verdict, comparison and bus tasks
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bounded count
    task automatic apb(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] st);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        chk(nm, rd, exp);
    endtask : rdc

    // Expected {reserved, e1, load, samples} for one shape code
    function automatic logic [31:0] dec(input int c);
        if (c == 0) return 32'h0000_004c;
        if (c == 8) return 32'h0000_005c;
        if (c == 1 || c == 2) return 32'h0000_002e;
        if (c >= 3 && c <= 7) return 32'h0000_002d;
        return 32'h0000_00b0;
    endfunction : dec

    // ==========================================================
    // Test sequence
    initial begin
        errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        ais_detect = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdc("reset reg", LCA_ADDR_CHAN_SEL + 8'(4 * i), 32'h0);
        end
        chk("reset e1 mode", chan_e1_mode, 32'h0000_00ff);
        $display("test reset done");
        // Each channel gets its own impedance bit and code
        for (int c = 0; c < 8; c++) begin
            wr(LCA_ADDR_CHAN_SEL, 32'(c));
            wr(LCA_ADDR_CFG_DATA, 32'((c * 9) % 32));
        end
        for (int c = 7; c >= 0; c--) begin
            wr(LCA_ADDR_CHAN_SEL, 32'(c));
            rdc("cfg data", LCA_ADDR_CFG_DATA, 32'((c * 9) % 32));
        end
        repeat (2) @(posedge pclk);
        for (int c = 0; c < 8; c++) begin
            chk("shape pins", pulse_shape_code[4*c +: 4],
                32'((c * 9) % 16));
            chk("imp pins", impedance_source_sel[c],
                32'(((c * 9) % 32) / 16));
        end
        wr(LCA_ADDR_CHAN_SEL, 32'h0000_00ff);
        rdc("index upper", LCA_ADDR_CHAN_SEL, 32'h7);
        wr(LCA_ADDR_CFG_DATA, 32'h0000_00ff);
        rdc("data upper", LCA_ADDR_CFG_DATA, 32'h1f);
        $display("test channels done");
        // Every shape code on channel 3
        wr(LCA_ADDR_CHAN_SEL, 32'h3);
        for (int k = 0; k < 16; k++) begin
            wr(LCA_ADDR_CFG_DATA, 32'(k));
            repeat (2) @(posedge pclk);
            chk("decode", {chan_shape_rsvd[3], chan_e1_mode[3],
                chan_line_load[7:6], chan_phase_samples[15:12]}, dec(k));
        end
        $display("test decode done");
        // Driver disable, strobe-less write, unmapped and read-only places
        wr(LCA_ADDR_HIZ, 32'h0000_00a5);
        rdc("hiz reg", LCA_ADDR_HIZ, 32'ha5);
        chk("hiz pins", tx_driver_hiz, 32'ha5);
        apb(1'b1, LCA_ADDR_HIZ, 32'h0000_005a, 4'h0);
        rdc("hiz strobe", LCA_ADDR_HIZ, 32'ha5);
        apb(1'b0, 8'h5c, 32'h0, 4'hf);
        chk("unmapped err", err, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wr(LCA_ADDR_AIS_STS, 32'h0000_00ff);
        rdc("status ro", LCA_ADDR_AIS_STS, 32'h0);
        $display("test access done");
        // Alarm with enable clear, then enabled, then cleared
        ais_detect <= 8'h02;
        repeat (8) @(posedge pclk);
        rdc("alarm_signal_status", LCA_ADDR_AIS_STS, 32'h02);
        rdc("irq masked", LCA_ADDR_IRQ_STS, 32'h0);
        chk("irq pin low", ais_irq, 32'h0);
        wr(LCA_ADDR_IRQ_EN, 32'h1);
        ais_detect <= 8'h03;
        repeat (8) @(posedge pclk);
        rdc("irq latched", LCA_ADDR_IRQ_STS, 32'h01);
        chk("irq pin high", ais_irq, 32'h1);
        ais_detect <= 8'h02;
        repeat (8) @(posedge pclk);
        rdc("irq held", LCA_ADDR_IRQ_STS, 32'h01);
        wr(LCA_ADDR_IRQ_STS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq pin clear", ais_irq, 32'h0);
        rdc("irq cleared", LCA_ADDR_IRQ_STS, 32'h0);
        $display("test alarm done");
        // Second reset wipes channel configs
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(LCA_ADDR_CHAN_SEL, 32'h3);
        rdc("cfg after reset", LCA_ADDR_CFG_DATA, 32'h0);
        rdc("hiz after reset", LCA_ADDR_HIZ, 32'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule : lca_regs_tb_top
